// ---- rtp_encoder.sv ----
// radio telegram payload encoder with apb registers and byte sender
//
// Overview of operation
// - each channel sends on value change and every fifteen minutes
// - after a send the channel stays silent for five seconds
// - fan room profile byte 3 codes fan 255,200,175,155,70
// - room profiles byte 2 scale set point offset over range
// - room and valve temperature inverted, 255 is 0 C, 0 is 40 C
// - byte 0 bit 3 is learn flag, 0 learn, 1 data
// - room profiles byte 0 bit 0 is occupancy, 1 occupied
// - room profile without fan leaves byte 3 unused
// - controller profile byte 3 is manipulating variable 0..100 pct
// - controller byte 2 fan: 0-3 manual, 16-19 auto, 255 unused
// - controller byte 1 is base plus offset over 0..51.2 C
// - controller byte 0 bit 7 alarm, bits 6-5 mode
// - controller byte 0 bit 4 is 0 automatic, 1 manual
// - controller byte 0 bit 2 set while energy reduction active
// - controller bits 1-0 occupancy 0 occ, 1 unocc, 3 frost
// - valve byte 3 is manipulating variable in pi modes
// - valve byte 3 is set point 0..40 C in bath or two-point
// - valve byte 2 temperature internal, or selected source in bath
// - valve byte 1 bit 3 energy reduction, bits 7-4 unused
// - valve byte 1 bit 2 selects variable or set point
// - valve byte 1 bit 1 heat or cool, bit 0 run control
// - one room, one controller and six valve channels
// - a learn telegram is sent when software requests it
`timescale 1ns/1ns

module rtp_encoder #(
  parameter logic [14:0] TICK_CYC = 15'(rtp_pkg::RTP_TICK_CYC),
  parameter logic [19:0] CYCLIC_TICKS = 20'(rtp_pkg::RTP_CYCLIC_TICKS),
  parameter logic [12:0] HOLD_TICKS = 13'(rtp_pkg::RTP_HOLD_TICKS)
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // register bus
  input wire rtp_pkg::rtp_apb_req_t apb_in,
  output rtp_pkg::rtp_apb_rsp_t apb_out,
  // transceiver byte stream
  input wire logic tx_ready_in,
  output rtp_pkg::rtp_tx_t tx_out
);
  import rtp_pkg::*;

  typedef struct packed {
    logic [RTP_NREG-1:0][31:0] regs;
    rtp_apb_rsp_t apb;
    logic [RTP_TICK_W-1:0] tick_cnt;
    logic [RTP_NCH-1:0] learn_req;
    logic [RTP_NCH-1:0][RTP_HOLD_W-1:0] hold;
    logic [RTP_NCH-1:0][RTP_CYC_W-1:0] cyc;
    logic [RTP_NCH-1:0][31:0] last;
    rtp_fsm_t fsm;
    logic [23:0] rest;
    logic [1:0] nbyte;
    rtp_tx_t tx;
  } rtp_state_t;

  rtp_state_t s_q;
  rtp_state_t s_d;

  // ==========================================================
  // scaling helpers

  // 0..40 C in tenths to 0..255
  function automatic logic [7:0] rtp_t40(input logic [9:0] t);
    logic [9:0] c;
    logic [19:0] p;
    c = (t > RTP_T40_MAX) ? RTP_T40_MAX : t;
    p = c * RTP_SCALE_MUL;
    return p[17:10];
  endfunction

  function automatic logic [7:0] rtp_tinv(input logic [9:0] t);
    return RTP_BYTE_MAX - rtp_t40(t);
  endfunction

  // 0..100 percent to 0..255
  function automatic logic [7:0] rtp_pct(input logic [7:0] y);
    logic [7:0] c;
    logic [17:0] p;
    c = (y > RTP_PCT_MAX) ? RTP_PCT_MAX : y;
    p = c * RTP_SCALE_MUL;
    return p[15:8];
  endfunction

  // 0..51.2 C in tenths to 0..255
  function automatic logic [7:0] rtp_sp512(input logic [9:0] sp);
    logic [9:0] c;
    c = (sp > RTP_SP512_MAX) ? RTP_SP512_MAX : sp;
    return c[8:1];
  endfunction

  // signed offset over -range..+range to 0..255
  function automatic logic [7:0] rtp_offs(input logic [7:0] off,
                                          input logic [7:0] rng);
    logic signed [9:0] o;
    logic signed [9:0] r;
    logic [8:0] u;
    logic [16:0] num;
    logic [16:0] den;
    r = signed'({2'b00, rng});
    o = signed'({{2{off[7]}}, off});
    if (o > r) begin
      o = r;
    end else if (o < -r) begin
      o = -r;
    end
    u = 9'(o + r);
    num = u * RTP_BYTE_MAX;
    den = {8'h00, rng, 1'b0};
    if (rng == 8'h00) begin
      return RTP_OFF_MID;
    end
    return 8'(num / den);
  endfunction

  function automatic logic [7:0] rtp_fan(input logic aut,
                                         input logic [1:0] st);
    logic [7:0] f;
    case (st)
      2'd0: f = RTP_FAN_S0;
      2'd1: f = RTP_FAN_S1;
      2'd2: f = RTP_FAN_S2;
      default: f = RTP_FAN_S3;
    endcase
    return aut ? RTP_FAN_AUTO : f;
  endfunction

  // ==========================================================
  // next state
  logic tick;
  logic access;
  logic [5:0] idx;
  logic [RTP_NCH-1:0] en;
  logic [RTP_NCH-1:0] pend;
  logic [RTP_NCH-1:0] lset;
  logic [RTP_NCH-1:0][31:0] pay;
  logic [31:0] room;
  logic [31:0] ctl;
  logic [31:0] v;
  logic [9:0] t;
  logic [9:0] eff;
  logic signed [11:0] es;
  logic [7:0] off;
  logic [7:0] rng;
  logic [7:0] tcfan;
  logic [7:0] b3;
  logic found;
  logic [2:0] sel;
  logic [31:0] word;

  always_comb begin
    s_d = s_q;
    t = '0;
    v = '0;
    word = '0;
    found = 1'b0;
    sel = '0;
    lset = '0;
    s_d.apb = '0;

    // millisecond time base
    tick = (s_q.tick_cnt == TICK_CYC - 15'd1);
    s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 15'd1;

    // --------------------------------------------------------
    // payload encoding, learn bit set means data telegram
    room = s_q.regs[RTP_IDX_ROOM];
    ctl = s_q.regs[RTP_IDX_CTLR];
    off = s_q.regs[RTP_IDX_SETPT][23:16];
    rng = s_q.regs[RTP_IDX_SETPT][31:24];
    en = {s_q.regs[RTP_IDX_CTRL][RTP_CTRL_VALVE_EN +: RTP_NVALVE],
          s_q.regs[RTP_IDX_CTRL][RTP_CTRL_CTL_EN],
          s_q.regs[RTP_IDX_CTRL][RTP_CTRL_ROOM_EN]};

    if (s_q.regs[RTP_IDX_CTRL][RTP_CTRL_ROOM_FAN]) begin
      b3 = rtp_fan(room[3], room[2:1]);
    end else begin
      b3 = 8'h00;
    end
    pay[RTP_CH_ROOM] = {b3,
                        rtp_offs(off, rng),
                        rtp_tinv(s_q.regs[RTP_IDX_TEMP][9:0]),
                        4'h0, 1'b1, 2'b00,
                        room[0]};

    es = signed'({2'b00, s_q.regs[RTP_IDX_SETPT][9:0]})
         + signed'({{4{off[7]}}, off});
    if (es < 0) begin
      eff = '0;
    end else if (es > signed'({2'b00, RTP_SP512_MAX})) begin
      eff = RTP_SP512_MAX;
    end else begin
      eff = es[9:0];
    end
    if (room[4]) begin
      tcfan = RTP_TC_FAN_UNUSED;
    end else begin
      tcfan = {3'b000, room[3], 2'b00, room[2:1]};
    end
    pay[RTP_CH_CTL] = {rtp_pct(ctl[7:0]),
                       tcfan,
                       rtp_sp512(eff),
                       ctl[8], ctl[10:9],
                       ctl[11],
                       1'b1,
                       ctl[12],
                       ctl[14:13]};

    for (int i = 0; i < RTP_NVALVE; i++) begin
      v = s_q.regs[RTP_IDX_VALVE0 + 6'(i)];
      t = s_q.regs[RTP_IDX_TEMP][9:0];
      if (v[24]) begin
        if (v[23:22] == 2'd1) begin
          t = s_q.regs[RTP_IDX_TEMP][25:16];
        end else if (v[23:22] == 2'd2) begin
          t = s_q.regs[RTP_IDX_RXTEMP][9:0];
        end
      end
      if (v[19]) begin
        b3 = rtp_t40(v[17:8]);
      end else begin
        b3 = rtp_pct(v[7:0]);
      end
      pay[RTP_CH_VALVE0 + i] = {b3, rtp_tinv(t),
                                4'h0,
                                v[18], v[19],
                                v[20], v[21],
                                4'h0, 1'b1, 3'b000};
    end

    // --------------------------------------------------------
    // per channel timers and send condition
    for (int c = 0; c < RTP_NCH; c++) begin
      if (tick && s_q.hold[c] != '0) begin
        s_d.hold[c] = s_q.hold[c] - 13'd1;
      end
      if (tick && s_q.cyc[c] != '0) begin
        s_d.cyc[c] = s_q.cyc[c] - 20'd1;
      end
      pend[c] = en[c] && (s_q.learn_req[c] || s_q.cyc[c] == '0 ||
                          pay[c] != s_q.last[c]);
      if (!en[c]) begin
        s_d.cyc[c] = '0;
        s_d.learn_req[c] = 1'b0;
      end
    end
    for (int c = RTP_NCH - 1; c >= 0; c--) begin
      if (pend[c] && s_q.hold[c] == '0) begin
        found = 1'b1;
        sel = 3'(c);
      end
    end

    // --------------------------------------------------------
    // register bus, one wait state
    access = apb_in.psel && apb_in.penable;
    idx = apb_in.paddr[7:2];
    if (access && !s_q.apb.pready) begin
      s_d.apb.pready = 1'b1;
      if (idx == RTP_IDX_STATUS) begin
        s_d.apb.prdata = {15'h0000, s_q.fsm == RTP_SEND,
                          pend, s_q.learn_req};
      end else if (idx == RTP_IDX_LEARN) begin
        s_d.apb.prdata = '0;
      end else if (idx <= RTP_IDX_RXTEMP) begin
        s_d.apb.prdata = s_q.regs[idx[3:0]];
      end else begin
        s_d.apb.pslverr = 1'b1;
      end
    end
    if (access && s_q.apb.pready && apb_in.pwrite) begin
      if (idx == RTP_IDX_LEARN) begin
        lset = apb_in.pwdata[RTP_NCH-1:0];
      end else if (idx <= RTP_IDX_RXTEMP) begin
        s_d.regs[idx[3:0]] = apb_in.pwdata & RTP_WMASK[idx[3:0]];
      end
    end

    // --------------------------------------------------------
    // sender, byte 3 first
    case (s_q.fsm)
      RTP_IDLE: begin
        if (found) begin
          word = pay[sel];
          if (s_q.learn_req[sel]) begin
            word = word & ~RTP_LEARN_MASK;
          end
          s_d.last[sel] = pay[sel];
          s_d.hold[sel] = HOLD_TICKS;
          s_d.cyc[sel] = CYCLIC_TICKS;
          s_d.learn_req[sel] = 1'b0;
          s_d.fsm = RTP_SEND;
          s_d.tx.valid = 1'b1;
          s_d.tx.last = 1'b0;
          s_d.tx.chan = sel;
          s_d.tx.data = word[31:24];
          s_d.rest = word[23:0];
          s_d.nbyte = 2'd0;
        end
      end
      RTP_SEND: begin
        if (tx_ready_in) begin
          if (s_q.tx.last) begin
            s_d.tx.valid = 1'b0;
            s_d.tx.last = 1'b0;
            s_d.fsm = RTP_IDLE;
          end else begin
            s_d.tx.data = s_q.rest[23:16];
            s_d.rest = {s_q.rest[15:0], 8'h00};
            s_d.tx.last = (s_q.nbyte == 2'd2);
            s_d.nbyte = s_q.nbyte + 2'd1;
          end
        end
      end
      default: begin
        s_d.fsm = RTP_IDLE;
        s_d.tx = '0;
      end
    endcase

    // a request in the cycle of its clear is kept
    s_d.learn_req = s_d.learn_req | (lset & en);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
      s_q.regs <= {RTP_NREG{RTP_RST_WORD}};
      s_q.fsm <= RTP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_out = s_q.apb;
  assign tx_out = s_q.tx;

endmodule

// ---- rtp_pkg.sv ----
// constants and carrier types of the radio telegram payload encoder
package rtp_pkg;

  // ==========================================================
  // clock and time base
  localparam int RTP_CLK_HZ = 20_000_000;
  localparam int RTP_TICK_HZ = 1000;
  localparam int RTP_TICK_CYC = RTP_CLK_HZ / RTP_TICK_HZ;
  localparam int RTP_CYCLIC_MIN = 15;
  localparam int RTP_CYCLIC_TICKS = RTP_CYCLIC_MIN * 60 * RTP_TICK_HZ;
  localparam int RTP_HOLD_S = 5;
  localparam int RTP_HOLD_TICKS = RTP_HOLD_S * RTP_TICK_HZ;
  localparam int RTP_TICK_W = 15;
  localparam int RTP_CYC_W = 20;
  localparam int RTP_HOLD_W = 13;

  // ==========================================================
  // channels
  localparam int RTP_NVALVE = 6;
  localparam int RTP_NCH = 8;
  localparam int RTP_CH_ROOM = 0;
  localparam int RTP_CH_CTL = 1;
  localparam int RTP_CH_VALVE0 = 2;

  // ==========================================================
  // register indexes, byte address is index times four
  localparam int RTP_NREG = 13;
  localparam logic [5:0] RTP_IDX_CTRL = 6'h00;
  localparam logic [5:0] RTP_IDX_LEARN = 6'h01;
  localparam logic [5:0] RTP_IDX_TEMP = 6'h02;
  localparam logic [5:0] RTP_IDX_SETPT = 6'h03;
  localparam logic [5:0] RTP_IDX_ROOM = 6'h04;
  localparam logic [5:0] RTP_IDX_CTLR = 6'h05;
  localparam logic [5:0] RTP_IDX_VALVE0 = 6'h06;
  localparam logic [5:0] RTP_IDX_RXTEMP = 6'h0C;
  localparam logic [5:0] RTP_IDX_STATUS = 6'h0D;
  localparam logic [31:0] RTP_RST_WORD = 32'h0000_0000;

  // writable bits per stored register, index 12 first
  localparam logic [RTP_NREG-1:0][31:0] RTP_WMASK = {
    32'h0000_03FF,
    32'h01FF_FFFF, 32'h01FF_FFFF, 32'h01FF_FFFF,
    32'h01FF_FFFF, 32'h01FF_FFFF, 32'h01FF_FFFF,
    32'h0000_7FFF,
    32'h0000_001F,
    32'hFFFF_03FF,
    32'h03FF_03FF,
    32'h0000_0000,
    32'h0000_3F07
  };

  // ==========================================================
  // field positions
  localparam int RTP_CTRL_ROOM_EN = 0;
  localparam int RTP_CTRL_ROOM_FAN = 1;
  localparam int RTP_CTRL_CTL_EN = 2;
  localparam int RTP_CTRL_VALVE_EN = 8;
  localparam int RTP_LEARN_BIT = 3;
  localparam logic [31:0] RTP_LEARN_MASK = 32'h0000_0008;

  // ==========================================================
  // codes and scaling
  localparam logic [7:0] RTP_FAN_AUTO = 8'hFF;
  localparam logic [7:0] RTP_FAN_S0 = 8'hC8;
  localparam logic [7:0] RTP_FAN_S1 = 8'hAF;
  localparam logic [7:0] RTP_FAN_S2 = 8'h9B;
  localparam logic [7:0] RTP_FAN_S3 = 8'h46;
  localparam logic [7:0] RTP_TC_FAN_UNUSED = 8'hFF;
  localparam logic [7:0] RTP_BYTE_MAX = 8'hFF;
  localparam logic [7:0] RTP_OFF_MID = 8'h80;
  localparam logic [9:0] RTP_T40_MAX = 10'h190;
  localparam logic [9:0] RTP_SP512_MAX = 10'h1FF;
  localparam logic [7:0] RTP_PCT_MAX = 8'h64;
  localparam logic [9:0] RTP_SCALE_MUL = 10'h28D;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rtp_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rtp_apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [2:0] chan;
    logic [7:0] data;
  } rtp_tx_t;

  typedef enum logic [1:0] {
    RTP_IDLE = 2'b01,
    RTP_SEND = 2'b10
  } rtp_fsm_t;

endpackage

// ---- rtp_encoder_monitor.sv ----
// port checker for the radio telegram payload encoder
`timescale 1ns/1ns
module rtp_encoder_monitor
  import rtp_pkg::*;
#(
  parameter logic [14:0] TICK_CYC = 15'h0004,
  parameter logic [12:0] HOLD_TICKS = 13'h0014
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // register bus
  input wire rtp_pkg::rtp_apb_req_t apb_in,
  input wire rtp_pkg::rtp_apb_rsp_t apb_out,
  // byte stream
  input wire logic tx_ready_in,
  input wire rtp_pkg::rtp_tx_t tx_out
);
  // ==========================================================
  // helpers
  localparam int HOLD_MIN = (int'(HOLD_TICKS) - 2) * int'(TICK_CYC);
  logic acc;
  logic [1:0] cnt_q;
  logic [31:0] gap_q;
  logic seen_q;
  assign acc = tx_out.valid && tx_ready_in;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cnt_q <= 2'h0;
      gap_q <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      if (acc) begin
        cnt_q <= tx_out.last ? 2'h0 : cnt_q + 2'h1;
      end
      if (acc && tx_out.last && tx_out.chan == 3'h0) begin
        gap_q <= 32'h0;
        seen_q <= 1'b1;
      end else if (gap_q != 32'hFFFF_FFFF) begin
        gap_q <= gap_q + 32'h1;
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================================
  // assertions
  a_tx_steady: assert property (tx_out.valid && !tx_ready_in |=>
    tx_out.valid && $stable(tx_out.data) && $stable(tx_out.chan))
    else $error("byte changed before accept");
  a_last_fourth: assert property (tx_out.valid |->
    tx_out.last == (cnt_q == 2'h3)) else $error("last not on fourth byte");
  a_tel_gap: assert property (acc && tx_out.last |=> !tx_out.valid)
    else $error("no idle cycle after telegram");
  a_chan_const: assert property (acc && !tx_out.last |=>
    tx_out.valid && tx_out.chan == $past(tx_out.chan))
    else $error("telegram broken or channel changed");
  a_room_holdoff: assert property (tx_out.valid && cnt_q == 2'h0 &&
    tx_out.chan == 3'h0 && seen_q |-> gap_q >= HOLD_MIN)
    else $error("room telegram inside hold-off");
  a_valve_spare: assert property (tx_out.valid && tx_out.chan >= 3'h2 &&
    cnt_q == 2'h2 |-> tx_out.data[7:4] == 4'h0)
    else $error("valve spare bits set");
  a_valve_byte0: assert property (tx_out.valid && tx_out.chan >= 3'h2 &&
    tx_out.last |-> (tx_out.data & 8'hF7) == 8'h00)
    else $error("valve byte 0 carries more than learn flag");
  a_ctl_fan: assert property (tx_out.valid && tx_out.chan == 3'h1 &&
    cnt_q == 2'h1 |-> tx_out.data <= 8'h03 || tx_out.data == 8'hFF ||
    (tx_out.data >= 8'h10 && tx_out.data <= 8'h13))
    else $error("illegal controller fan code");
  a_room_byte0: assert property (tx_out.valid && tx_out.chan == 3'h0 &&
    tx_out.last |-> (tx_out.data & 8'hF6) == 8'h00)
    else $error("room byte 0 unused bits set");
  a_apb_wait: assert property (apb_in.psel && !apb_in.penable ##1
    apb_in.psel && apb_in.penable |=> apb_out.pready)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (apb_out.pready |=> !apb_out.pready)
    else $error("pready longer than one cycle");
  a_err_map: assert property (apb_out.pready |->
    apb_out.pslverr == (apb_in.paddr[7:2] > 6'h0D))
    else $error("slave error does not match address map");
  c_tel: cover property (acc && tx_out.last);
  c_stall: cover property (tx_out.valid && !tx_ready_in);
  c_err: cover property (apb_out.pready && apb_out.pslverr);
endmodule

bind rtp_encoder rtp_encoder_monitor #(
  .TICK_CYC(TICK_CYC),
  .HOLD_TICKS(HOLD_TICKS)
) rtp_encoder_monitor_i (
  .clk_in(clk_in),
  .rst_b_in(rst_b_in),
  .apb_in(apb_in),
  .apb_out(apb_out),
  .tx_ready_in(tx_ready_in),
  .tx_out(tx_out)
);

// ---- rtp_xcvr_model.sv ----
// transceiver model that accepts and collects telegrams
`timescale 1ns/1ns
module rtp_xcvr_model
  import rtp_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // stall request from the bench
  input wire logic stall_in,
  // byte stream
  input wire rtp_pkg::rtp_tx_t tx_in,
  output logic ready_out
);
  logic [31:0] words[$];
  logic [2:0] chans[$];
  int stamps[$];
  logic [31:0] w = 32'h0;
  int cyc = 0;
  initial ready_out = 1'b0;
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (rst_b_in && tx_in.valid && ready_out) begin
      // first byte in is payload byte 3
      w = {w[23:0], tx_in.data};
      if (tx_in.last) begin
        words.push_back(w);
        chans.push_back(tx_in.chan);
        stamps.push_back(cyc);
      end
    end
    // stalling accepts on every other pair of cycles
    ready_out <= rst_b_in && (!stall_in || cyc[1]);
  end
endmodule

// ---- rtp_encoder_bench.sv ----
// self-checking bench for the radio telegram payload encoder
`timescale 1ns/1ns
module rtp_encoder_bench;
  import rtp_pkg::*;
  localparam int HOLD_C = 80;
  localparam int CYC_C = 800;
  localparam logic [2:0][31:0] RM = {32'h17, 32'h0F, 32'h01};
  localparam logic [2:0][7:0] FN = {8'hFF, 8'h13, 8'h00};
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic stall = 1'b0;
  logic tx_ready;
  rtp_apb_req_t req = '0;
  rtp_apb_rsp_t rsp;
  rtp_tx_t tx;
  int failures = 0;
  int n_checks = 0;
  int last_t = 0;
  logic [31:0] rd;
  logic err;
  always #25 clk_in = ~clk_in;
  rtp_encoder #(
    .TICK_CYC(15'h0004),
    .CYCLIC_TICKS(20'h000C8),
    .HOLD_TICKS(13'h0014)
  ) rtp_encoder_i (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .apb_in(req),
    .apb_out(rsp),
    .tx_ready_in(tx_ready),
    .tx_out(tx)
  );
  rtp_xcvr_model rtp_xcvr_model_i (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .stall_in(stall),
    .tx_in(tx),
    .ready_out(tx_ready)
  );
  // ==========================================================
  // tasks
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic wr, input logic [5:0] idx,
                      input logic [31:0] wd);
    int n;
    @(posedge clk_in);
    req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, wd};
    @(posedge clk_in);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask
  task automatic rdchk(input string nm, input logic [5:0] idx,
                       input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(nm, rd, exp);
  endtask
  task automatic get(input logic [31:0] ew, input logic [2:0] ec,
                     output int gap);
    int n;
    int t;
    n = 0;
    gap = 0;
    while (rtp_xcvr_model_i.words.size() == 0 && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    if (rtp_xcvr_model_i.words.size() == 0) begin
      check("telegram arrival", 32'h0, 32'h1);
      return;
    end
    check("payload", rtp_xcvr_model_i.words.pop_front(), ew);
    check("channel", {29'h0, rtp_xcvr_model_i.chans.pop_front()}, {29'h0, ec});
    t = rtp_xcvr_model_i.stamps.pop_front();
    gap = t - last_t;
    last_t = t;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog
  initial begin
    #1500000;
    failures++;
    wrap_up();
  end
  // ==========================================================
  // tests
  initial begin
    int g;
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rdchk("ctrl reset", RTP_IDX_CTRL, 32'h0);
    rdchk("status reset", RTP_IDX_STATUS, 32'h0);
    check("mapped err", {31'h0, err}, 32'h0);
    xfer(1'b0, 6'h0E, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    wr(RTP_IDX_STATUS, 32'hFFFF_FFFF);
    rdchk("status ro", RTP_IDX_STATUS, 32'h0);
    $display("test registers done");
    wr(RTP_IDX_TEMP, 32'h0064_00C8);
    wr(RTP_IDX_SETPT, 32'h1E00_00D2);
    wr(RTP_IDX_ROOM, 32'h0000_0005);
    wr(RTP_IDX_CTRL, 32'h0000_0003);
    get(32'h9B7F_8009, 3'h0, g);
    wr(RTP_IDX_ROOM, 32'h0000_0007);
    get(32'h467F_8009, 3'h0, g);
    check("holdoff gap", {31'h0, g >= HOLD_C - 4 && g <= HOLD_C + 20}, 1);
    get(32'h467F_8009, 3'h0, g);
    check("cyclic gap", {31'h0, g >= CYC_C - 8 && g <= CYC_C + 16}, 1);
    wr(RTP_IDX_LEARN, 32'h0000_0001);
    get(32'h467F_8001, 3'h0, g);
    wr(RTP_IDX_CTRL, 32'h0000_0001);
    get(32'h007F_8009, 3'h0, g);
    $display("test room profiles done");
    wr(RTP_IDX_CTLR, 32'h0000_7B32);
    wr(RTP_IDX_CTRL, 32'h0000_0004);
    get(32'h7F03_69BF, 3'h1, g);
    for (int i = 0; i < 3; i++) begin
      wr(RTP_IDX_ROOM, RM[i]);
      get({8'h7F, FN[i], 16'h69BF}, 3'h1, g);
    end
    $display("test controller profile done");
    wr(RTP_IDX_VALVE0, 32'h0014_0064);
    wr(RTP_IDX_VALVE0 + 6'h01, 32'h0169_2C00);
    stall <= 1'b1;
    wr(RTP_IDX_CTRL, 32'h0000_0300);
    get(32'hFF80_0A08, 3'h2, g);
    get(32'hBFC0_0508, 3'h3, g);
    $display("test valve channels done");
    wrap_up();
  end
endmodule
